/* File: hdl/supervision_timer.sv */
// Windowed supervision timer with protected configuration and Avalon-MM slave
`timescale 1ns/1ps
// Function
// RULE1: Counter reaching the timeout without restart raises a full device reset.
// RULE2: Eleven timeout choices from eight milliseconds up to eight seconds.
// RULE3: Counter advances only on the one kilohertz always-on oscillator tick.
// RULE4: Once enabled the counter runs continuously and never pauses itself.
// RULE5: Processor issues the restart instruction before the timeout elapses.
// RULE6: Normal and window modes; window mode resets on early or late restart.
// RULE7: Counter keeps operating in active and all sleep modes.
// RULE8: Counter keeps running and can reset even with main clocks stopped. Here the counter logic is clocked by clk, the bus clock.
// RULE9: Settings change only through a keyed, protected write sequence.
// RULE10: Nonvolatile lock input freezes the configuration against software writes.
// RULE11: After reset all clock sources off except the always-on oscillator.
// RULE12: Restarts and configuration take effect only at the tick boundary.
// RULE13: Timeout choices are doublings of an eight tick base period.
module supervision_timer
   import supervision_timer_pkg::*;
(
   input wire logic clk,
   input wire logic resetn,
   input wire logic [ADDR_W-1:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [DATA_W-1:0] avs_writedata,
   output logic [DATA_W-1:0] avs_readdata,
   output logic avs_waitrequest,
   input wire logic restartInstr,
   input wire logic aoTick,
   input wire logic lockFuse,
   output logic sysReset,
   output logic [NUM_CLK_SRC-1:0] clkSrcEnable,
   output logic aoOscEnable
);
   localparam int MIN_TICKS = BASE_TICKS;
   localparam int MAX_TICKS = BASE_TICKS << (NUM_PERIODS - 1);

   // Selections above the top choice saturate instead of aliasing
   function automatic logic [CNT_W-1:0] selTicks(input logic [3:0] sel);
      logic [3:0] s;
      s = (sel > MAX_SEL) ? MAX_SEL : sel;
      return CNT_W'(BASE_TICKS) << s; // [RULE13] [RULE2]
   endfunction : selTicks

   // Bus and configuration state
   logic waitReg, waitNext;
   logic [DATA_W-1:0] readReg, readNext;
   wd_cfg_t cfgReg, cfgNext;
   logic [2:0] unlockReg, unlockNext;
   logic dirtyReg, dirtyNext;
   logic [NUM_CLK_SRC-1:0] clkEnReg, clkEnNext;
   // Counter state
   wd_state_t stateReg, stateNext;
   wd_cfg_t activeReg, activeNext;
   logic [CNT_W-1:0] cntReg, cntNext;
   logic pendReg, pendNext;
   logic fireReg, fireNext;
   logic aoOscReg;

   logic busReq, wrAcc, cfgWrite;
   logic restartNow, earlyHit, timeoutHit;
   logic [CNT_W-1:0] closedTicks, openTicks, limitTicks, cntInc;

   assign busReq = avs_read | avs_write;
   assign wrAcc = avs_write & ~waitReg;
   assign closedTicks = selTicks(activeReg.closedSel);
   assign openTicks = selTicks(activeReg.periodSel);
   assign limitTicks = activeReg.windowMode ? CNT_W'(closedTicks + openTicks) : openTicks;
   assign cntInc = CNT_W'(cntReg + 1'b1);
   // A restart issued in the tick cycle itself is taken with that tick
   assign restartNow = pendReg | restartInstr;
   assign earlyHit = activeReg.windowMode & (cntReg < closedTicks); // [RULE6]
   assign timeoutHit = cntInc >= limitTicks;

   always_comb begin
      waitNext = 1'b1;
      readNext = readReg;
      cfgNext = cfgReg;
      clkEnNext = clkEnReg;
      cfgWrite = 1'b0;
      unlockNext = (unlockReg != 3'h0) ? 3'(unlockReg - 1'b1) : 3'h0;
      // One wait state: data is latched on the first edge, handed over on the second
      if (busReq && waitReg) begin
         waitNext = 1'b0;
         readNext = '0;
         unique case (avs_address)
            OFS_CTRL: begin
               readNext[CTRL_ENABLE_BIT] = cfgReg.enable;
               readNext[CTRL_WINMODE_BIT] = cfgReg.windowMode;
               readNext[CTRL_PERSEL_LSB +: 4] = cfgReg.periodSel;
            end
            OFS_WINDOW: readNext[WIN_SEL_LSB +: 4] = cfgReg.closedSel;
            OFS_STATUS: begin
               readNext[STAT_RUN_BIT] = (stateReg == ST_RUN);
               readNext[STAT_PEND_BIT] = dirtyReg | pendReg;
               readNext[STAT_LOCK_BIT] = lockFuse;
               readNext[STAT_FIRE_BIT] = fireReg;
               readNext[STAT_CNT_LSB +: CNT_W] = cntReg;
            end
            OFS_PROTECT: readNext[0] = (unlockReg != 3'h0);
            OFS_CLKEN: readNext[NUM_CLK_SRC-1:0] = clkEnReg;
            default: readNext = '0;
         endcase
      end
      if (wrAcc) begin
         unique case (avs_address)
            OFS_PROTECT: begin
               if (avs_writedata[7:0] == PROTECT_KEY && !lockFuse) begin // [RULE10]
                  unlockNext = PROTECT_CYCLES; // [RULE9]
               end
            end
            OFS_CTRL: begin
               if (unlockReg != 3'h0 && !lockFuse) begin // [RULE9] [RULE10]
                  cfgNext.enable = avs_writedata[CTRL_ENABLE_BIT];
                  cfgNext.windowMode = avs_writedata[CTRL_WINMODE_BIT];
                  cfgNext.periodSel = avs_writedata[CTRL_PERSEL_LSB +: 4];
                  cfgWrite = 1'b1;
                  unlockNext = 3'h0;
               end
            end
            OFS_WINDOW: begin
               if (unlockReg != 3'h0 && !lockFuse) begin // [RULE9] [RULE10]
                  cfgNext.closedSel = avs_writedata[WIN_SEL_LSB +: 4];
                  cfgWrite = 1'b1;
                  unlockNext = 3'h0;
               end
            end
            OFS_CLKEN: clkEnNext = avs_writedata[NUM_CLK_SRC-1:0];
            default: ;
         endcase
      end
      // A write in the tick cycle keeps the flag set, so it is applied next tick
      dirtyNext = cfgWrite | (dirtyReg & ~aoTick); // [RULE12]
   end

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         waitReg <= 1'b1;
         readReg <= '0;
         cfgReg <= CFG_RESET;
         unlockReg <= 3'h0;
         dirtyReg <= 1'b0;
         clkEnReg <= CLKEN_RESET; // [RULE11]
         aoOscReg <= 1'b1; // [RULE11]
      end else begin
         waitReg <= waitNext;
         readReg <= readNext;
         cfgReg <= cfgNext;
         unlockReg <= unlockNext;
         dirtyReg <= dirtyNext;
         clkEnReg <= clkEnNext;
         aoOscReg <= 1'b1;
      end
   end

   // Counter logic is clocked by clk, the bus clock, but counts only on the oscillator tick
   always_comb begin
      stateNext = stateReg;
      activeNext = activeReg;
      cntNext = cntReg;
      pendNext = aoTick ? 1'b0 : (pendReg | restartInstr); // [RULE12]
      if (aoTick && dirtyReg) begin
         activeNext = cfgReg; // [RULE12]
      end
      unique case (stateReg)
         ST_OFF: begin
            cntNext = '0;
            if (activeReg.enable) begin
               stateNext = ST_RUN;
            end
         end
         ST_RUN: begin
            if (!activeReg.enable) begin
               stateNext = ST_OFF;
               cntNext = '0;
            end else if (aoTick) begin // [RULE3] [RULE7] [RULE8]
               if (restartNow) begin
                  if (earlyHit) begin
                     stateNext = ST_FIRE; // [RULE6]
                  end else begin
                     cntNext = '0;
                  end
               end else if (timeoutHit) begin
                  stateNext = ST_FIRE; // [RULE1] [RULE6]
               end else begin
                  cntNext = cntInc; // [RULE4]
               end
            end
         end
         // Only resetn going low, from whatever source, brings it out of here
         ST_FIRE: cntNext = cntReg;
      endcase
      fireNext = (stateNext == ST_FIRE); // [RULE1]
   end

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         stateReg <= ST_OFF;
         activeReg <= CFG_RESET;
         cntReg <= '0;
         pendReg <= 1'b0;
         fireReg <= 1'b0;
      end else begin
         stateReg <= stateNext;
         activeReg <= activeNext;
         cntReg <= cntNext;
         pendReg <= pendNext;
         fireReg <= fireNext;
      end
   end

   assign avs_waitrequest = waitReg;
   assign avs_readdata = readReg;
   assign sysReset = fireReg;
   assign clkSrcEnable = clkEnReg;
   assign aoOscEnable = aoOscReg;

   a_timeout_reset: assert property (@(posedge clk) disable iff (!resetn) // [RULE1]
      (stateReg == ST_RUN && activeReg.enable && aoTick && !restartNow && timeoutHit)
      |=> sysReset [*3])
      else $error("timeout did not raise reset");
   a_window_early: assert property (@(posedge clk) disable iff (!resetn) // [RULE6]
      (stateReg == ST_RUN && activeReg.enable && aoTick && restartNow && earlyHit)
      |=> sysReset)
      else $error("early restart in window mode did not raise reset");
   a_restart_clears: assert property (@(posedge clk) disable iff (!resetn) // [RULE6]
      (stateReg == ST_RUN && activeReg.enable && aoTick && restartNow && !earlyHit)
      |=> cntReg == '0 && !sysReset)
      else $error("accepted restart did not clear counter");
   a_counter_advance: assert property (@(posedge clk) disable iff (!resetn) // [RULE4]
      (stateReg == ST_RUN && activeReg.enable && aoTick && !restartNow && !timeoutHit)
      |=> cntReg == $past(cntReg) + 1'b1)
      else $error("counter did not advance on tick");
   a_tick_only: assert property (@(posedge clk) disable iff (!resetn) // [RULE3]
      (stateReg == ST_RUN && activeReg.enable && !aoTick) |=> $stable(cntReg))
      else $error("counter moved without a tick");
   a_period_range: assert property (@(posedge clk) disable iff (!resetn) // [RULE2]
      openTicks >= MIN_TICKS && openTicks <= MAX_TICKS)
      else $error("timeout period outside the selectable range");
   a_protected_write: assert property (@(posedge clk) disable iff (!resetn) // [RULE9]
      (wrAcc && unlockReg == 3'h0 && (avs_address == OFS_CTRL || avs_address == OFS_WINDOW))
      |=> $stable(cfgReg))
      else $error("unprotected write changed configuration");
   a_fuse_lock: assert property (@(posedge clk) disable iff (!resetn) // [RULE10]
      lockFuse |=> $stable(cfgReg))
      else $error("configuration changed while locked");
   a_sync_restart: assert property (@(posedge clk) disable iff (!resetn) // [RULE12]
      ((restartInstr || pendReg) && !aoTick) |=> pendReg)
      else $error("restart request was not held until the tick");
   // Registers are already reset at the sampled edge, so the edge after shows reset values
   a_clock_reset: assert property (@(posedge clk) // [RULE11]
      !resetn |=> aoOscEnable && clkSrcEnable == CLKEN_RESET)
      else $error("clock sources not in reset state");

   // Bus handshake: exactly one wait state per access, so a master never stalls longer
   a_wait_one_cycle: assert property (@(posedge clk) disable iff (!resetn) // [RULE9]
      !avs_waitrequest |=> avs_waitrequest)
      else $error("waitrequest stayed low for more than one cycle");
   a_wait_answer: assert property (@(posedge clk) disable iff (!resetn) // [RULE9]
      (busReq && avs_waitrequest) |=> !avs_waitrequest)
      else $error("bus request was not answered after one wait state");
   // The reset request is sticky: only resetn takes it away
   a_fire_holds: assert property (@(posedge clk) disable iff (!resetn) // [RULE1]
      sysReset |=> sysReset)
      else $error("reset request dropped before resetn");
   a_fire_state: assert property (@(posedge clk) disable iff (!resetn) // [RULE1]
      sysReset == (stateReg == ST_FIRE))
      else $error("reset output disagrees with the counter state");
   a_clken_write: assert property (@(posedge clk) disable iff (!resetn) // [RULE11]
      (wrAcc && avs_address == OFS_CLKEN)
      |=> clkSrcEnable == $past(avs_writedata[NUM_CLK_SRC-1:0]))
      else $error("clock enable write was not applied");
   a_osc_on: assert property (@(posedge clk) disable iff (!resetn) // [RULE11]
      aoOscEnable)
      else $error("always-on oscillator was switched off");
   // A write near a tick must never be lost on its way to the counter side
   a_config_held: assert property (@(posedge clk) disable iff (!resetn) // [RULE12]
      ((cfgWrite || dirtyReg) && !aoTick) |=> dirtyReg)
      else $error("pending configuration lost before the tick");
   a_config_apply: assert property (@(posedge clk) disable iff (!resetn) // [RULE12]
      (aoTick && dirtyReg) |=> activeReg == $past(cfgReg))
      else $error("pending configuration not applied on the tick");
   a_key_unlock: assert property (@(posedge clk) disable iff (!resetn) // [RULE9]
      (wrAcc && avs_address == OFS_PROTECT && avs_writedata[7:0] == PROTECT_KEY && !lockFuse)
      |=> unlockReg == PROTECT_CYCLES)
      else $error("key write did not open the unlock window");
   a_disable_stops: assert property (@(posedge clk) disable iff (!resetn) // [RULE4]
      (stateReg == ST_RUN && !activeReg.enable) |=> stateReg == ST_OFF && cntReg == '0)
      else $error("disabled counter did not stop and clear");
   // Two longest periods back to back is the furthest the counter can ever get
   a_count_ceiling: assert property (@(posedge clk) disable iff (!resetn) // [RULE2]
      cntReg < 2 * MAX_TICKS)
      else $error("counter beyond the longest window");

   c_timeout: cover property (@(posedge clk) disable iff (!resetn)
      $rose(sysReset) && !$past(activeReg.windowMode));
   c_early: cover property (@(posedge clk) disable iff (!resetn)
      stateReg == ST_RUN && aoTick && restartNow && earlyHit);
   c_restart: cover property (@(posedge clk) disable iff (!resetn)
      stateReg == ST_RUN && aoTick && restartNow && !earlyHit && activeReg.windowMode);
   c_config: cover property (@(posedge clk) disable iff (!resetn)
      cfgWrite ##[1:20] (aoTick && dirtyReg));
   c_window_timeout: cover property (@(posedge clk) disable iff (!resetn)
      $rose(sysReset) && $past(activeReg.windowMode));
endmodule : supervision_timer

/* File: hdl/supervision_timer_pkg.sv */
// Constants, register map and types for the supervision timer
package supervision_timer_pkg;
   localparam int ADDR_W = 5;
   localparam int DATA_W = 32;
   localparam logic [ADDR_W-1:0] OFS_CTRL = 5'h00;
   localparam logic [ADDR_W-1:0] OFS_WINDOW = 5'h04;
   localparam logic [ADDR_W-1:0] OFS_STATUS = 5'h08;
   localparam logic [ADDR_W-1:0] OFS_PROTECT = 5'h0c;
   localparam logic [ADDR_W-1:0] OFS_CLKEN = 5'h10;
   // Field positions
   localparam int CTRL_ENABLE_BIT = 0;
   localparam int CTRL_WINMODE_BIT = 1;
   localparam int CTRL_PERSEL_LSB = 4;
   localparam int WIN_SEL_LSB = 0;
   localparam int STAT_RUN_BIT = 0;
   localparam int STAT_PEND_BIT = 1;
   localparam int STAT_LOCK_BIT = 2;
   localparam int STAT_FIRE_BIT = 3;
   localparam int STAT_CNT_LSB = 16;
   // Unlock key and how many clk cycles the unlock lasts
   localparam logic [7:0] PROTECT_KEY = 8'hd8;
   localparam logic [2:0] PROTECT_CYCLES = 3'h4;
   // Timeout periods, counted in ticks of the always-on oscillator
   localparam int TICK_HZ = 1000;
   localparam int MIN_PERIOD_MS = 8;
   localparam int MAX_PERIOD_MS = 8000;
   localparam int BASE_TICKS = MIN_PERIOD_MS * TICK_HZ / 1000;
   localparam int NUM_PERIODS = 11;
   localparam logic [3:0] MAX_SEL = 4'(NUM_PERIODS - 1);
   localparam int CNT_W = 15;
   localparam int NUM_CLK_SRC = 4;
   localparam logic [NUM_CLK_SRC-1:0] CLKEN_RESET = 4'h0;
   typedef struct packed {
      logic enable;
      logic windowMode;
      logic [3:0] periodSel;
      logic [3:0] closedSel;
   } wd_cfg_t;
   localparam wd_cfg_t CFG_RESET = '{enable: 1'b0, windowMode: 1'b0,
                                     periodSel: 4'h0, closedSel: 4'h0};
   typedef enum logic [2:0] {
      ST_OFF = 3'b001,
      ST_RUN = 3'b010,
      ST_FIRE = 3'b100
   } wd_state_t;
endpackage : supervision_timer_pkg

/* File: tb/restart_core_model.sv */
// Processor core model issuing restart instructions after a chosen lag
`timescale 1ns/1ps
module restart_core_model (
   input wire logic clk,
   input wire logic resetn,
   input wire logic kickReq,
   input wire logic [1:0] lag,
   output logic restartInstr
);
   logic [2:0] waitReg;
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         waitReg <= 3'h0;
         restartInstr <= 1'b0;
      end else begin
         restartInstr <= (waitReg == 3'h1); // One-cycle restart instruction
         if (kickReq) begin
            waitReg <= {1'b0, lag} + 3'h1;
         end else if (waitReg != 3'h0) begin
            waitReg <= waitReg - 3'h1;
         end
      end
   end
endmodule : restart_core_model

/* File: tb/supervision_timer_test.sv */
// Self-checking bench for the supervision timer
`timescale 1ns/1ps
module supervision_timer_test
   import supervision_timer_pkg::*;
;
   localparam int LIMIT = 90000;
   logic clk = 1'b0, resetn = 1'b0, avsRead = 1'b0, avsWrite = 1'b0;
   logic aoTick = 1'b0, lockFuse = 1'b0, kickReq = 1'b0, sysReset, aoOscEnable;
   logic avsWaitrequest, restartInstr;
   logic [1:0] lag = 2'h0, tickDiv = 2'h0;
   logic [ADDR_W-1:0] avsAddress = '0;
   logic [DATA_W-1:0] avsWritedata = '0, avsReaddata, q, s1;
   logic [NUM_CLK_SRC-1:0] clkSrcEnable;
   int errorCnt = 0, checksDone = 0, cycles = 0;
   always #20 clk = ~clk;
   // Tick every 4 clk keeps the 8 s period inside the run budget
   always @(posedge clk) begin
      tickDiv <= tickDiv + 2'h1;
      aoTick <= (tickDiv == 2'h3);
   end
   supervision_timer dut (.clk(clk), .resetn(resetn), .avs_address(avsAddress),
      .avs_read(avsRead), .avs_write(avsWrite), .avs_writedata(avsWritedata),
      .avs_readdata(avsReaddata), .avs_waitrequest(avsWaitrequest),
      .restartInstr(restartInstr), .aoTick(aoTick), .lockFuse(lockFuse),
      .sysReset(sysReset), .clkSrcEnable(clkSrcEnable), .aoOscEnable(aoOscEnable));
   restart_core_model core (.clk(clk), .resetn(resetn), .kickReq(kickReq), .lag(lag),
      .restartInstr(restartInstr));
   task automatic report_and_stop();
      $display("comparisons %0d mismatches %0d", checksDone, errorCnt);
      if (errorCnt == 0 && checksDone > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask : report_and_stop
   always @(posedge clk) begin
      cycles <= cycles + 1;
      if (cycles == LIMIT) begin
         errorCnt++;
         report_and_stop();
      end
   end
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checksDone++;
      if (got !== exp) begin
         errorCnt++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk
   task automatic bus(input logic wr, input logic [ADDR_W-1:0] a,
                      input logic [DATA_W-1:0] d, output logic [DATA_W-1:0] r);
      @(posedge clk);
      avsAddress <= a;
      avsWritedata <= d;
      avsWrite <= wr;
      avsRead <= !wr;
      // Only the bench cycle limit ends a wait that never completes
      do begin
         @(posedge clk);
      end while (avsWaitrequest !== 1'b0);
      r = avsReaddata;
      avsWrite <= 1'b0;
      avsRead <= 1'b0;
   endtask : bus
   task automatic pwr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
      bus(1'b1, OFS_PROTECT, 32'(PROTECT_KEY), q);
      bus(1'b1, a, d, q);
   endtask : pwr
   task automatic doReset();
      resetn <= 1'b0;
      repeat (16) @(posedge clk);
      resetn <= 1'b1;
      @(posedge clk);
   endtask : doReset
   task automatic ticks(input int n);
      repeat (n) begin
         @(posedge clk);
         while (aoTick !== 1'b1) @(posedge clk);
      end
   endtask : ticks
   task automatic kick();
      @(posedge clk);
      kickReq <= 1'b1;
      @(posedge clk);
      kickReq <= 1'b0;
   endtask : kick
   task automatic runPeriod(input int sel);
      int n;
      n = 0;
      doReset();
      pwr(OFS_CTRL, 32'(sel << 4) | 32'h1);
      while (sysReset !== 1'b1 && n < (8 << sel) + 4) begin
         @(posedge clk);
         if (aoTick === 1'b1) n++;
      end
      chk(32'(n), 32'((8 << sel) + 1));
   endtask : runPeriod
   initial begin
      doReset();
      chk({27'h0, clkSrcEnable, aoOscEnable}, 32'h1);
      bus(1'b1, OFS_CLKEN, 32'h5, q);
      // The write lands on the edge the task returns at; look one edge later
      @(posedge clk);
      chk({28'h0, clkSrcEnable}, 32'h5);
      bus(1'b0, 5'h14, 32'h0, q);
      chk(q, 32'h0);
      $display("test reset and clocks done");
      bus(1'b1, OFS_CTRL, 32'h1, q);
      bus(1'b0, OFS_CTRL, 32'h0, q);
      chk(q, 32'h0);
      lockFuse <= 1'b1;
      pwr(OFS_CTRL, 32'h1);
      bus(1'b0, OFS_CTRL, 32'h0, q);
      chk(q, 32'h0);
      bus(1'b0, OFS_STATUS, 32'h0, q);
      chk({31'h0, q[STAT_LOCK_BIT]}, 32'h1);
      lockFuse <= 1'b0;
      $display("test protection done");
      for (int s = 0; s < NUM_PERIODS; s++) runPeriod(s);
      $display("test periods done");
      lag <= 2'h3;
      doReset();
      pwr(OFS_CTRL, 32'h31);
      bus(1'b0, OFS_STATUS, 32'h0, s1);
      ticks(5);
      bus(1'b0, OFS_STATUS, 32'h0, q);
      chk({30'h0, q[STAT_CNT_LSB+:CNT_W] > s1[STAT_CNT_LSB+:CNT_W], q[0]}, 32'h3);
      ticks(50);
      kick();
      ticks(50);
      chk({31'h0, sysReset}, 32'h0);
      $display("test normal restart done");
      lag <= 2'h0;
      doReset();
      pwr(OFS_WINDOW, 32'h0);
      pwr(OFS_CTRL, 32'h3);
      ticks(3);
      kick();
      ticks(3);
      chk({31'h0, sysReset}, 32'h1);
      bus(1'b0, OFS_STATUS, 32'h0, q);
      chk({31'h0, q[STAT_FIRE_BIT]}, 32'h1);
      doReset();
      pwr(OFS_CTRL, 32'h3);
      ticks(11);
      kick();
      ticks(10);
      chk({31'h0, sysReset}, 32'h0);
      ticks(8);
      chk({31'h0, sysReset}, 32'h1);
      $display("test window done");
      report_and_stop();
   end
endmodule : supervision_timer_test
